//--- rtl/nrr_defs.svh
`ifndef NRR_DEFS_SVH
`define NRR_DEFS_SVH

// Register offsets (byte addresses)
`define NRR_OFS_CTRL      8'h00
`define NRR_OFS_HAM0      8'h10
`define NRR_OFS_HAM1      8'h14
`define NRR_OFS_HAM2      8'h18
`define NRR_OFS_HAM3      8'h1c
`define NRR_OFS_LOAD      8'h20
`define NRR_OFS_RES1      8'h24
`define NRR_OFS_RES2      8'h28

// Control fields
`define NRR_CTRL_EN_LSB   0
`define NRR_CTRL_MB_BIT   4
`define NRR_CTRL_W16_BIT  8

// Parity result layout
`define NRR_ODD_LSB       16
`define NRR_EVEN_LSB      0
`define NRR_PAR_W         12

// Multi-bit fields
`define NRR_SYM_W         10
`define NRR_VAL_LO_LSB    0
`define NRR_VAL_HI_LSB    16

// Reset values
`define NRR_RST_CTRL      32'h0000_0000
`define NRR_RST_SYM       10'h000
`define NRR_RST_PAR       12'h000

// Field polynomial x^10 + x^3 + 1, feedback bits
`define NRR_GF_POLY       10'h009

`endif

//--- rtl/nrr_pkg.sv
package nrr_pkg;
	typedef logic [9:0] nrr_sym_t;
	typedef logic [11:0] nrr_par_t;
	typedef enum logic {
		NRR_W8  = 1'b0,
		NRR_W16 = 1'b1
	} nrr_width_t;
endpackage

//--- rtl/nrr_parity_acc.sv
`timescale 1ns/100ps
`default_nettype none
`include "nrr_defs.svh"

module nrr_parity_acc
	import nrr_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Control
	input  wire logic        clr,
	input  wire nrr_width_t  width,
	// Data beat
	input  wire logic        vld,
	input  wire logic [15:0] data,
	// Accumulated parities
	output var  nrr_par_t    odd_r,
	output var  nrr_par_t    even_r
);

	logic     [8:0] cnt_r;
	nrr_par_t       po;
	nrr_par_t       pe;

	genvar gk;
	generate
		for (gk = 0; gk < `NRR_PAR_W; gk++) begin : g_w
			localparam int R8  = (gk >= 3) ? gk - 3 : 0;
			localparam int R16 = (gk >= 4) ? gk - 4 : 0;
			localparam logic [15:0] MSK = (gk < 4) ? (
				(gk == 0) ? 16'haaaa : (gk == 1) ? 16'hcccc :
				(gk == 2) ? 16'hf0f0 : 16'hff00) : 16'h0000;
			always_comb begin
				if (width == NRR_W8) begin
					if (gk < 3) begin // see RULE_01
						po[gk] = ^(data[7:0] & MSK[7:0]);
						pe[gk] = ^(data[7:0] & ~MSK[7:0]);
					end else begin // see RULE_01
						po[gk] = cnt_r[R8] & (^data[7:0]);
						pe[gk] = ~cnt_r[R8] & (^data[7:0]);
					end
				end else begin
					if (gk < 4) begin // see RULE_02
						po[gk] = ^(data & MSK);
						pe[gk] = ^(data & ~MSK);
					end else begin // see RULE_02
						po[gk] = cnt_r[R16] & (^data);
						pe[gk] = ~cnt_r[R16] & (^data);
					end
				end
			end
		end
	endgenerate

	// Byte or word position in the page
	always_ff @(posedge sys_clk) begin
		if (!rst_b || clr) begin
			cnt_r <= 9'h000;
		end else if (vld) begin
			cnt_r <= cnt_r + 9'h001;
		end
	end

	// Parity accumulation
	always_ff @(posedge sys_clk) begin
		if (!rst_b || clr) begin
			odd_r  <= `NRR_RST_PAR;
			even_r <= `NRR_RST_PAR;
		end else if (vld) begin // see RULE_03
			odd_r  <= odd_r ^ po;
			even_r <= even_r ^ pe;
		end
	end

	property p_col8;
		@(posedge sys_clk) disable iff (!rst_b)
		(vld && !clr && width == NRR_W8) |=>
			odd_r[0] == ($past(odd_r[0]) ^ (^($past(data[7:0]) & 8'haa)));
	endproperty
	a_col8: assert property (p_col8) else $error("8-bit column parity wrong"); // see RULE_01

	property p_col16;
		@(posedge sys_clk) disable iff (!rst_b)
		(vld && !clr && width == NRR_W16) |=>
			odd_r[3] == ($past(odd_r[3]) ^ (^($past(data) & 16'hff00)));
	endproperty
	a_col16: assert property (p_col16) else $error("16-bit column parity wrong"); // see RULE_02

	property p_hold;
		@(posedge sys_clk) disable iff (!rst_b)
		(!vld && !clr) |=> ($stable(odd_r) && $stable(even_r));
	endproperty
	a_hold: assert property (p_hold) else $error("Parity changed without data"); // see RULE_03

endmodule // nrr_parity_acc

`default_nettype wire

//--- rtl/nrr_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "nrr_defs.svh"

// How it works
// RULE_01 - 8-bit: weights 1-4 column, rest row
// RULE_02 - 16-bit: weights 1-8 column, rest row
// RULE_03 - Parity during transfer; odd high, even low
// RULE_04 - Parity registers read-only, reset zero, gaps zero
// RULE_05 - Four independent parity result registers
// RULE_06 - Load writes feed the syndrome calculation
// RULE_07 - Values one, two in first result register
// RULE_08 - Values three, four in second, reset zero
// RULE_09 - Software reads results after transfer completes

module nrr_regs
	import nrr_pkg::*;
#(
	parameter int NUM_HAM = 4,
	parameter int NUM_SYM = 4
)
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata_r,
	// NAND data beats
	input  wire logic        nand_xfer_vld,
	input  wire logic [1:0]  nand_cs_sel,
	input  wire logic [15:0] nand_xfer_data
);

	logic [NUM_HAM-1:0] ham_en_r;
	logic               mb_en_r;
	nrr_width_t         width_r;
	nrr_sym_t           code_load_field_r;
	nrr_sym_t           sym_r [NUM_SYM];
	nrr_par_t           odd_q [NUM_HAM];
	nrr_par_t           even_q [NUM_HAM];
	logic [NUM_HAM-1:0] ham_clr;
	logic [NUM_HAM-1:0] ham_vld;
	logic               wr_ctrl;
	logic               wr_load;
	logic               wr_res1;
	logic               wr_res2;
	logic               mb_clr;
	logic               mb_feed;
	nrr_sym_t           beat_sym;
	logic [31:0]        rd_mux;

	function automatic nrr_sym_t gf_mul_a(input nrr_sym_t v, input int n);
		nrr_sym_t r;
		r = v;
		for (int i = 0; i < n; i++) begin
			r = {r[8:0], 1'b0} ^ (r[9] ? `NRR_GF_POLY : 10'h000);
		end
		return r;
	endfunction

	function automatic logic [31:0] pack_ham(input nrr_par_t o, input nrr_par_t e);
		return {4'h0, o, 4'h0, e};
	endfunction

	function automatic logic [31:0] pack_pair(input nrr_sym_t hi, input nrr_sym_t lo);
		return {6'h00, hi, 6'h00, lo};
	endfunction

	// Write decode
	assign wr_ctrl = reg_wr && (reg_addr == `NRR_OFS_CTRL);
	assign wr_load = reg_wr && (reg_addr == `NRR_OFS_LOAD);
	assign wr_res1 = reg_wr && (reg_addr == `NRR_OFS_RES1);
	assign wr_res2 = reg_wr && (reg_addr == `NRR_OFS_RES2);

	// Control register
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ham_en_r  <= '0;
			mb_en_r   <= 1'b0;
			width_r   <= NRR_W8;
		end else if (wr_ctrl) begin
			ham_en_r  <= reg_wdata[`NRR_CTRL_EN_LSB +: NUM_HAM];
			mb_en_r   <= reg_wdata[`NRR_CTRL_MB_BIT];
			width_r   <= nrr_width_t'(reg_wdata[`NRR_CTRL_W16_BIT]);
		end
	end

	// Newly enabled units restart from zero
	assign ham_clr = wr_ctrl ? (reg_wdata[`NRR_CTRL_EN_LSB +: NUM_HAM] & ~ham_en_r) : '0;
	assign mb_clr  = wr_ctrl && reg_wdata[`NRR_CTRL_MB_BIT] && !mb_en_r;

	// Hamming parity units
	genvar gi;
	generate
		for (gi = 0; gi < NUM_HAM; gi++) begin : g_ham
			assign ham_vld[gi] = nand_xfer_vld && ham_en_r[gi]
				&& (nand_cs_sel == 2'(gi)); // see RULE_05
			nrr_parity_acc u_acc (
				.sys_clk (sys_clk),
				.rst_b   (rst_b),
				.clr     (ham_clr[gi]),
				.width   (width_r),
				.vld     (ham_vld[gi]),
				.data    (nand_xfer_data),
				.odd_r   (odd_q[gi]),
				.even_r  (even_q[gi])
			);
		end
	endgenerate

	// Multi-bit symbol from a data beat
	assign beat_sym = (width_r == NRR_W16) ? nand_xfer_data[9:0]
		: {2'h0, nand_xfer_data[7:0]};
	assign mb_feed  = nand_xfer_vld && mb_en_r && !wr_load;

	// Load field holds the last stored code word
	always_ff @(posedge sys_clk) begin
		if (!rst_b || mb_clr) begin
			code_load_field_r <= `NRR_RST_SYM;
		end else if (wr_load) begin // see RULE_06
			code_load_field_r <= reg_wdata[`NRR_SYM_W-1:0];
		end
	end

	// Syndrome / code accumulators, one per value
	always_ff @(posedge sys_clk) begin
		if (!rst_b || mb_clr) begin
			for (int j = 0; j < NUM_SYM; j++) begin
				sym_r[j] <= `NRR_RST_SYM;
			end
		end else if (wr_load) begin
			for (int j = 0; j < NUM_SYM; j++) begin // see RULE_06
				sym_r[j] <= gf_mul_a(sym_r[j], j + 1) ^ reg_wdata[`NRR_SYM_W-1:0];
			end
		end else if (wr_res1) begin // see RULE_07
			sym_r[0] <= reg_wdata[`NRR_VAL_LO_LSB +: `NRR_SYM_W];
			sym_r[1] <= reg_wdata[`NRR_VAL_HI_LSB +: `NRR_SYM_W];
		end else if (wr_res2) begin // see RULE_08
			sym_r[2] <= reg_wdata[`NRR_VAL_LO_LSB +: `NRR_SYM_W];
			sym_r[3] <= reg_wdata[`NRR_VAL_HI_LSB +: `NRR_SYM_W];
		end else if (mb_feed) begin
			for (int j = 0; j < NUM_SYM; j++) begin
				sym_r[j] <= gf_mul_a(sym_r[j], j + 1) ^ beat_sym;
			end
		end
	end

	// Read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_addr)
			`NRR_OFS_CTRL: begin
				rd_mux[`NRR_CTRL_EN_LSB +: NUM_HAM] = ham_en_r;
				rd_mux[`NRR_CTRL_MB_BIT]            = mb_en_r;
				rd_mux[`NRR_CTRL_W16_BIT]           = width_r;
			end
			`NRR_OFS_HAM0: rd_mux = pack_ham(odd_q[0], even_q[0]); // see RULE_04
			`NRR_OFS_HAM1: rd_mux = pack_ham(odd_q[1], even_q[1]);
			`NRR_OFS_HAM2: rd_mux = pack_ham(odd_q[2], even_q[2]);
			`NRR_OFS_HAM3: rd_mux = pack_ham(odd_q[3], even_q[3]);
			`NRR_OFS_LOAD: rd_mux = {22'h00_0000, code_load_field_r};
			`NRR_OFS_RES1: rd_mux = pack_pair(sym_r[1], sym_r[0]); // see RULE_07
			`NRR_OFS_RES2: rd_mux = pack_pair(sym_r[3], sym_r[2]); // see RULE_08
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data stand one cycle only
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			reg_rdata_r <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata_r <= rd_mux;
		end else begin
			reg_rdata_r <= 32'h0000_0000;
		end
	end

	// Checks
	sequence s_rd_ham;
		reg_rd && (reg_addr == `NRR_OFS_HAM0 || reg_addr == `NRR_OFS_HAM1
			|| reg_addr == `NRR_OFS_HAM2 || reg_addr == `NRR_OFS_HAM3);
	endsequence

	sequence s_rd_res1;
		reg_rd && reg_addr == `NRR_OFS_RES1;
	endsequence

	sequence s_rd_res2;
		reg_rd && reg_addr == `NRR_OFS_RES2;
	endsequence

	sequence s_wr_load;
		reg_wr && reg_addr == `NRR_OFS_LOAD;
	endsequence

	property p_ham_gaps;
		@(posedge sys_clk) disable iff (!rst_b)
		s_rd_ham |=> (reg_rdata_r[31:28] == 4'h0 && reg_rdata_r[15:12] == 4'h0);
	endproperty
	a_ham_gaps: assert property (p_ham_gaps) else $error("Parity gap bits not zero"); // see RULE_04

	property p_ham0_layout;
		@(posedge sys_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == `NRR_OFS_HAM0) |=>
			(reg_rdata_r[27:16] == $past(odd_q[0]) && reg_rdata_r[11:0] == $past(even_q[0]));
	endproperty
	a_ham0_layout: assert property (p_ham0_layout) else $error("Parity layout wrong"); // see RULE_03

	property p_ham_separate;
		@(posedge sys_clk) disable iff (!rst_b)
		(ham_clr[0] && !ham_vld[1] && !ham_clr[1]) |=>
			(odd_q[0] == 12'h000 && even_q[0] == 12'h000 && $stable(odd_q[1]));
	endproperty
	a_ham_separate: assert property (p_ham_separate) else $error("Parity units coupled"); // see RULE_05

	property p_load_feed;
		@(posedge sys_clk) disable iff (!rst_b)
		s_wr_load |=>
			(sym_r[0] == (gf_mul_a($past(sym_r[0]), 1) ^ $past(reg_wdata[9:0])))
			&& (code_load_field_r == $past(reg_wdata[9:0]));
	endproperty
	a_load_feed: assert property (p_load_feed) else $error("Load not fed to syndrome"); // see RULE_06

	property p_res1;
		@(posedge sys_clk) disable iff (!rst_b)
		s_rd_res1 |=> (reg_rdata_r == {6'h00, $past(sym_r[1]), 6'h00, $past(sym_r[0])});
	endproperty
	a_res1: assert property (p_res1) else $error("First result register wrong"); // see RULE_07

	property p_res2;
		@(posedge sys_clk) disable iff (!rst_b)
		s_rd_res2 |=> (reg_rdata_r == {6'h00, $past(sym_r[3]), 6'h00, $past(sym_r[2])});
	endproperty
	a_res2: assert property (p_res2) else $error("Second result register wrong"); // see RULE_08

	property p_res2_reset;
		@(posedge sys_clk)
		!rst_b |=> (sym_r[2] == 10'h000 && sym_r[3] == 10'h000 && reg_rdata_r == 32'h0);
	endproperty
	a_res2_reset: assert property (p_res2_reset) else $error("Results not cleared by reset"); // see RULE_08

	property p_ham_reset;
		@(posedge sys_clk)
		!rst_b |=> (odd_q[2] == 12'h000 && even_q[3] == 12'h000);
	endproperty
	a_ham_reset: assert property (p_ham_reset) else $error("Parity not cleared by reset"); // see RULE_04

	property p_ham_ro;
		@(posedge sys_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == `NRR_OFS_HAM1 && !ham_vld[1]) |=> $stable(odd_q[1]);
	endproperty
	a_ham_ro: assert property (p_ham_ro) else $error("Parity register writable"); // see RULE_04

	sequence s_rd_load;
		reg_rd && reg_addr == `NRR_OFS_LOAD;
	endsequence

	sequence s_wr_res1;
		reg_wr && reg_addr == `NRR_OFS_RES1;
	endsequence

	sequence s_wr_res2;
		reg_wr && reg_addr == `NRR_OFS_RES2;
	endsequence

	property p_ham3_layout;
		@(posedge sys_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == `NRR_OFS_HAM3) |=>
			(reg_rdata_r[27:16] == $past(odd_q[3]) && reg_rdata_r[11:0] == $past(even_q[3]));
	endproperty
	a_ham3_layout: assert property (p_ham3_layout) else $error("Unit 3 layout wrong"); // see RULE_05

	property p_load_gaps;
		@(posedge sys_clk) disable iff (!rst_b)
		s_rd_load |=> (reg_rdata_r[31:10] == 22'h00_0000);
	endproperty
	a_load_gaps: assert property (p_load_gaps) else $error("Load gap bits not zero"); // see RULE_06

	property p_res_gaps;
		@(posedge sys_clk) disable iff (!rst_b)
		(reg_rd && (reg_addr == `NRR_OFS_RES1 || reg_addr == `NRR_OFS_RES2)) |=>
			(reg_rdata_r[31:26] == 6'h00 && reg_rdata_r[15:10] == 6'h00);
	endproperty
	a_res_gaps: assert property (p_res_gaps) else $error("Result gap bits not zero"); // see RULE_07

	property p_rdata_idle;
		@(posedge sys_clk) disable iff (!rst_b)
		!reg_rd |=> (reg_rdata_r == 32'h0000_0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without a read");

	property p_load_feed4;
		@(posedge sys_clk) disable iff (!rst_b)
		s_wr_load |=>
			(sym_r[3] == (gf_mul_a($past(sym_r[3]), 4) ^ $past(reg_wdata[9:0])));
	endproperty
	a_load_feed4: assert property (p_load_feed4) else $error("Load not fed to value four"); // see RULE_06

	property p_beat_feed;
		@(posedge sys_clk) disable iff (!rst_b)
		(mb_feed && !reg_wr) |=>
			(sym_r[1] == (gf_mul_a($past(sym_r[1]), 2) ^ $past(beat_sym)));
	endproperty
	a_beat_feed: assert property (p_beat_feed) else $error("Data beat not fed"); // see RULE_07

	property p_res1_write;
		@(posedge sys_clk) disable iff (!rst_b)
		s_wr_res1 |=>
			(sym_r[0] == $past(reg_wdata[9:0]) && sym_r[1] == $past(reg_wdata[25:16]));
	endproperty
	a_res1_write: assert property (p_res1_write) else $error("First result write lost"); // see RULE_07

	property p_res2_write;
		@(posedge sys_clk) disable iff (!rst_b)
		s_wr_res2 |=>
			(sym_r[2] == $past(reg_wdata[9:0]) && sym_r[3] == $past(reg_wdata[25:16]));
	endproperty
	a_res2_write: assert property (p_res2_write) else $error("Second result write lost"); // see RULE_08

	property p_mb_clear;
		@(posedge sys_clk) disable iff (!rst_b)
		mb_clr |=>
			(code_load_field_r == 10'h000 && sym_r[0] == 10'h000 && sym_r[3] == 10'h000);
	endproperty
	a_mb_clear: assert property (p_mb_clear) else $error("Multibit state not cleared"); // see RULE_06

	property p_par_idle;
		@(posedge sys_clk) disable iff (!rst_b)
		(!nand_xfer_vld && !wr_ctrl) |=> ($stable(odd_q[0]) && $stable(even_q[0])
			&& $stable(odd_q[3]) && $stable(even_q[3]));
	endproperty
	a_par_idle: assert property (p_par_idle) else $error("Parity moved without transfer"); // see RULE_03

	property p_unarmed;
		@(posedge sys_clk) disable iff (!rst_b)
		(nand_xfer_vld && !ham_en_r[2] && !wr_ctrl) |=>
			($stable(odd_q[2]) && $stable(even_q[2]));
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("Disabled unit accumulated"); // see RULE_05

endmodule // nrr_regs

`default_nettype wire

//--- verification/nrr_nand_model.sv
`timescale 1ns/100ps
`default_nettype none

module nrr_nand_model (
	// Clock
	input  wire logic        sys_clk,
	// Data beats
	output var  logic        vld,
	output var  logic [1:0]  sel,
	output var  logic [15:0] data
);
	initial begin
		vld  = 1'b0;
		sel  = 2'h0;
		data = 16'h0000;
	end

	// One beat per call
	task automatic beat(input logic [1:0] s, input logic [15:0] d);
		@(posedge sys_clk);
		vld  <= 1'b1;
		sel  <= s;
		data <= d;
	endtask

	// Released bus shows inverted stale data
	task automatic idle();
		@(posedge sys_clk);
		vld  <= 1'b0;
		data <= ~data;
	endtask
endmodule // nrr_nand_model

`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "nrr_defs.svh"

module tb_top
	import nrr_pkg::*;
;
	logic        sys_clk;
	logic        rst_b;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata_r;
	logic        vld;
	logic [1:0]  sel;
	logic [15:0] data;
	int          n_mismatch;
	int          n_compared;
	logic [11:0] e_odd [4];
	logic [11:0] e_even [4];
	int          cnt [4];
	nrr_sym_t    syn [4];
	logic [7:0]  ofs [9] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h40};
	logic [9:0]  lds [3] = '{10'h3ff, 10'h2a5, 10'h001};

	nrr_regs u_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.nand_xfer_vld(vld), .nand_cs_sel(sel), .nand_xfer_data(data)
	);
	nrr_nand_model u_nand (.sys_clk(sys_clk), .vld(vld), .sel(sel), .data(data));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Read one register and compare
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 chk($sformatf("reg %h", a), e, reg_rdata_r);
	endtask

	// Expected parities of one beat
	task automatic model(input int s, input logic [15:0] d, input int w);
		logic [11:0] ad;
		for (int b = 0; b < w; b++) begin
			if (d[b]) begin
				ad = 12'(cnt[s] * w + b);
				for (int k = 0; k < 12; k++) begin
					if (ad[k]) e_odd[s][k] ^= 1'b1;
					else e_even[s][k] ^= 1'b1;
				end
			end
		end
		cnt[s]++;
	endtask

	// Interleaved beats to all four units, then check each
	task automatic run(input int w, input int n);
		logic [15:0] d;
		for (int s = 0; s < 4; s++) begin
			e_odd[s] = 12'h000;
			e_even[s] = 12'h000;
			cnt[s] = 0;
		end
		for (int i = 0; i < n; i++) begin
			for (int s = 0; s < 4; s++) begin
				d = 16'(i * 37 + s * 91 + 1);
				u_nand.beat(2'(s), d);
				model(s, d, w);
			end
		end
		u_nand.idle();
		for (int s = 0; s < 4; s++) begin
			rchk(8'(`NRR_OFS_HAM0 + 4 * s), {4'h0, e_odd[s], 4'h0, e_even[s]});
		end
	endtask

	function automatic nrr_sym_t mula(input nrr_sym_t x);
		return {x[8:0], 1'b0} ^ (x[9] ? `NRR_GF_POLY : 10'h000);
	endfunction
	task automatic upd(input nrr_sym_t v);
		foreach (syn[j]) begin
			repeat (j + 1) syn[j] = mula(syn[j]);
			syn[j] ^= v;
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge sys_clk);
		n_mismatch++;
		conclude();
	end

	initial begin
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		foreach (ofs[i]) rchk(ofs[i], 32'h0000_0000);
		$display("test reset values done");
		wr(`NRR_OFS_CTRL, 32'h0000_000f);
		run(8, 260);
		wr(`NRR_OFS_HAM1, 32'hffff_ffff);
		rchk(`NRR_OFS_HAM1, {4'h0, e_odd[1], 4'h0, e_even[1]});
		$display("test 8-bit parity done");
		wr(`NRR_OFS_CTRL, 32'h0000_0000);
		wr(`NRR_OFS_CTRL, 32'h0000_010e);
		wr(`NRR_OFS_CTRL, 32'h0000_010f);
		rchk(`NRR_OFS_CTRL, 32'h0000_010f);
		run(16, 140);
		$display("test 16-bit parity done");
		wr(`NRR_OFS_CTRL, 32'h0000_0000);
		wr(`NRR_OFS_CTRL, 32'h0000_0010);
		foreach (syn[j]) syn[j] = 10'h000;
		foreach (lds[i]) begin
			wr(`NRR_OFS_LOAD, {22'h3fffff, lds[i]});
			upd(lds[i]);
			rchk(`NRR_OFS_LOAD, {22'h0, lds[i]});
		end
		u_nand.beat(2'h0, 16'hff5a);
		u_nand.idle();
		upd(10'h05a);
		rchk(`NRR_OFS_RES1, {6'h0, syn[1], 6'h0, syn[0]});
		rchk(`NRR_OFS_RES2, {6'h0, syn[3], 6'h0, syn[2]});
		wr(`NRR_OFS_RES1, 32'hffff_ffff);
		rchk(`NRR_OFS_RES1, 32'h03ff_03ff);
		wr(`NRR_OFS_RES2, 32'h1234_5678);
		rchk(`NRR_OFS_RES2, 32'h0234_0278);
		$display("test multibit done");
		conclude();
	end
endmodule // tb_top

`default_nettype wire
